// File: core/csr_pkg.sv
/*
  Shared constants and types for the configuration start and reset control.
  Assumes a single 40 MHz pclk and a 32-bit APB register port.
*/
package csr_pkg;

  localparam int APB_AW = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PROGRAM_INSTRUCTION_BIT = 1;

  localparam int STAT_READY_BIT = 0;
  localparam int STAT_AUTO_BIT = 1;
  localparam int STAT_WAIT_N_BIT = 2;
  localparam int STAT_BYPASS_BIT = 3;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_START_BIT = 6;
  localparam int STAT_PROGRAM_INSTRUCTION_BIT = 7;

  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic CARD_ATTR_IDLE = 1'b1;

  localparam int CLK_NS = 25;
  localparam int POR_NS = 1000;
  localparam int PROGRAM_INSTRUCTION_NS = 500;
  // Least times, rounded up to whole cycles
  localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_INSTRUCTION_CYC = (PROGRAM_INSTRUCTION_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROGRAM_INSTRUCTION = 2'b01,
    ST_WAIT = 2'b11,
    ST_LOAD = 2'b10
  } csr_state_t;

  typedef struct packed {
    logic auto_start;
    logic bypass;
    logic por_reset;
    logic ready;
    logic card_wait_n;
  } csr_pins_t;

endpackage

// File: core/csr_sync.sv
/*
  Two-flop synchroniser for a group of slow pin levels.
  Assumes inputs are quasi-static levels from outside the pclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module csr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: core/csr_por.sv
/*
  Power-on reset source selection: internal timed reset or board reset.
  Assumes bypass and board reset are already synchronised to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module csr_por #(
  parameter int POR_CYCLES = csr_pkg::POR_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bypass,
  input wire logic ext_reset,
  output logic core_rst_q
);
  localparam int CW = $clog2(POR_CYCLES + 1);
  localparam logic [CW-1:0] LIM = CW'(POR_CYCLES);

  logic [CW-1:0] cnt_q;
  logic int_busy;

  assign int_busy = (cnt_q != LIM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (int_busy) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Bypass hands the whole reset decision to the board
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= bypass ? ext_reset : int_busy;
    end
  end
endmodule
`default_nettype wire

// File: core/csr_top.sv
/*
  Configuration start and reset control with an APB register port.
  Assumes pclk at 40 MHz, pins asynchronous, and an external loader that
  shifts data while load_en_out is high and pulses load_done_in at the end.
*/
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module csr_top #(
  parameter int POR_CYCLES = csr_pkg::POR_CYC,
  parameter int PROGRAM_INSTRUCTION_CYCLES = csr_pkg::PROGRAM_INSTRUCTION_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csr_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic auto_start_select_in,
  input wire logic por_bypass_in,
  input wire logic por_reset_in,
  input wire logic target_ready_in,
  input wire logic card_wait_in,
  input wire logic load_done_in,
  output logic target_program_out,
  output logic target_program_oe_n,
  output logic card_attr_select_out,
  output logic por_test_out,
  output logic load_en_out
);
  localparam int PW = $clog2(PROGRAM_INSTRUCTION_CYCLES + 1);
  localparam logic [PW-1:0] PROGRAM_INSTRUCTION_LIM = PW'(PROGRAM_INSTRUCTION_CYCLES);

  csr_pkg::csr_pins_t pins_raw;
  csr_pkg::csr_pins_t pins_s;
  csr_pkg::csr_state_t state_q;
  csr_pkg::csr_state_t state_d;
  logic core_rst;
  logic core_rst_prev_q;
  logic auto_go;
  logic start_q;
  logic program_instruction_q;
  logic program_instruction_only_q;
  logic program_instruction_low_q;
  logic load_en_q;
  logic por_test_q;
  logic [PW-1:0] program_instruction_cnt_q;
  logic [31:0] prdata_q;
  logic setup;
  logic wr;
  logic hit_ctrl;
  logic hit_stat;
  logic take;

  assign pins_raw = '{auto_start: auto_start_select_in,
                      bypass: por_bypass_in,
                      por_reset: por_reset_in,
                      ready: target_ready_in,
                      card_wait_n: card_wait_in};

  csr_sync #(
    .W($bits(csr_pkg::csr_pins_t)),
    .INIT(5'h01)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins_raw),
    .q(pins_s)
  );

  csr_por #(
    .POR_CYCLES(POR_CYCLES)
  ) u_por (
    .pclk(pclk),
    .presetn(presetn),
    .bypass(pins_s.bypass),
    .ext_reset(pins_s.por_reset),
    .core_rst_q(core_rst)
  );

  // APB: zero wait states, data fetched in the setup cycle
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign hit_ctrl = (paddr == csr_pkg::CTRL_OFS);
  assign hit_stat = (paddr == csr_pkg::STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_stat);
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= csr_pkg::ZERO32;
    end else if (setup) begin
      prdata_q <= csr_pkg::ZERO32;
      if (hit_ctrl) begin
        prdata_q[csr_pkg::CTRL_START_BIT] <= start_q;
        prdata_q[csr_pkg::CTRL_PROGRAM_INSTRUCTION_BIT] <= program_instruction_q;
      end else if (hit_stat) begin
        prdata_q[csr_pkg::STAT_READY_BIT] <= pins_s.ready;
        prdata_q[csr_pkg::STAT_AUTO_BIT] <= pins_s.auto_start;
        prdata_q[csr_pkg::STAT_WAIT_N_BIT] <= pins_s.card_wait_n;
        prdata_q[csr_pkg::STAT_BYPASS_BIT] <= pins_s.bypass;
        prdata_q[csr_pkg::STAT_STATE_LSB +: 2] <= state_q;
        prdata_q[csr_pkg::STAT_START_BIT] <= start_q;
        prdata_q[csr_pkg::STAT_PROGRAM_INSTRUCTION_BIT] <= program_instruction_low_q;
      end
    end
  end

  // One-shot at the end of the reset sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rst_prev_q <= 1'b1;
    end else begin
      core_rst_prev_q <= core_rst;
    end
  end

  assign auto_go = core_rst_prev_q & ~core_rst & pins_s.auto_start;
  assign take = (state_q == csr_pkg::ST_IDLE) & ~core_rst;

  // Host requests: a write in the same cycle as the take wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      program_instruction_q <= 1'b0;
    end else if (core_rst) begin
      start_q <= 1'b0;
      program_instruction_q <= 1'b0;
    end else begin
      if (wr && hit_ctrl && pwdata[csr_pkg::CTRL_START_BIT]) begin
        start_q <= 1'b1;
      end else if (take) begin
        start_q <= 1'b0;
      end
      if (wr && hit_ctrl && pwdata[csr_pkg::CTRL_PROGRAM_INSTRUCTION_BIT]) begin
        program_instruction_q <= 1'b1;
      end else if (take && !start_q) begin
        program_instruction_q <= 1'b0;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      csr_pkg::ST_IDLE: begin
        if (auto_go || start_q || program_instruction_q) begin
          state_d = csr_pkg::ST_PROGRAM_INSTRUCTION;
        end
      end
      csr_pkg::ST_PROGRAM_INSTRUCTION: begin
        if (program_instruction_cnt_q == PROGRAM_INSTRUCTION_LIM) begin
          state_d = program_instruction_only_q ? csr_pkg::ST_IDLE : csr_pkg::ST_WAIT;
        end
      end
      csr_pkg::ST_WAIT: begin
        if (pins_s.ready) begin
          state_d = csr_pkg::ST_LOAD;
        end
      end
      csr_pkg::ST_LOAD: begin
        if (load_done_in) begin
          state_d = csr_pkg::ST_IDLE;
        end else if (!pins_s.ready) begin
          state_d = csr_pkg::ST_WAIT;
        end
      end
      default: begin
        state_d = csr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= csr_pkg::ST_IDLE;
      program_instruction_low_q <= 1'b0;
      load_en_q <= 1'b0;
    end else if (core_rst) begin
      state_q <= csr_pkg::ST_IDLE;
      program_instruction_low_q <= 1'b0;
      load_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      program_instruction_low_q <= (state_d == csr_pkg::ST_PROGRAM_INSTRUCTION);
      load_en_q <= (state_d == csr_pkg::ST_LOAD);
    end
  end

  // Program-only request returns to idle without loading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_instruction_only_q <= 1'b0;
    end else if (take) begin
      program_instruction_only_q <= program_instruction_q & ~start_q & ~auto_go;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_instruction_cnt_q <= '0;
    end else if (state_q == csr_pkg::ST_PROGRAM_INSTRUCTION && !core_rst) begin
      program_instruction_cnt_q <= program_instruction_cnt_q + PW'(1);
    end else begin
      program_instruction_cnt_q <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_test_q <= 1'b1;
    end else begin
      por_test_q <= core_rst;
    end
  end

  // Open drain: only ever drives low, released otherwise
  assign target_program_out = 1'b0;
  assign target_program_oe_n = ~program_instruction_low_q;
  assign card_attr_select_out = csr_pkg::CARD_ATTR_IDLE;
  assign por_test_out = por_test_q;
  assign load_en_out = load_en_q;

  property p_attr_high;
    @(posedge pclk) disable iff (!presetn)
    card_attr_select_out == 1'b1;
  endproperty
  a_attr_high: assert property (p_attr_high)
    else $error("card select left high level");

  property p_no_self_start;
    @(posedge pclk) disable iff (!presetn)
    (state_q == csr_pkg::ST_IDLE && !start_q && !program_instruction_q && !auto_go)
      |=> state_q == csr_pkg::ST_IDLE;
  endproperty
  a_no_self_start: assert property (p_no_self_start)
    else $error("configuration began without a request");

  property p_auto_start;
    @(posedge pclk) disable iff (!presetn)
    auto_go |=> state_q == csr_pkg::ST_PROGRAM_INSTRUCTION ##1 !target_program_oe_n;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("automatic start missing after reset");

  property p_program_instruction_pin;
    @(posedge pclk) disable iff (!presetn)
    $fell(target_program_oe_n) |-> state_q == csr_pkg::ST_PROGRAM_INSTRUCTION
      ##1 !target_program_oe_n [*2];
  endproperty
  a_program_instruction_pin: assert property (p_program_instruction_pin)
    else $error("program pin pulse wrong");

  property p_ready_gate;
    @(posedge pclk) disable iff (!presetn)
    $rose(load_en_out) |-> $past(pins_s.ready);
  endproperty
  a_ready_gate: assert property (p_ready_gate)
    else $error("loading began while targets not ready");

  property p_not_ready_stops;
    @(posedge pclk) disable iff (!presetn)
    (load_en_out && !pins_s.ready && !load_done_in && !core_rst)
      |=> !load_en_out;
  endproperty
  a_not_ready_stops: assert property (p_not_ready_stops)
    else $error("loading continued while targets clearing");

  property p_bypass_release;
    @(posedge pclk) disable iff (!presetn)
    (pins_s.bypass && !pins_s.por_reset) |=> !core_rst;
  endproperty
  a_bypass_release: assert property (p_bypass_release)
    else $error("internal reset not bypassed");

  property p_board_reset;
    @(posedge pclk) disable iff (!presetn)
    (pins_s.bypass && pins_s.por_reset) |=> core_rst
      ##1 (state_q == csr_pkg::ST_IDLE && !load_en_out && por_test_out);
  endproperty
  a_board_reset: assert property (p_board_reset)
    else $error("board reset did not reset the block");

  property p_por_test;
    @(posedge pclk) disable iff (!presetn)
    $fell(core_rst) |=> !por_test_out;
  endproperty
  a_por_test: assert property (p_por_test)
    else $error("reset test output not low after reset");

  c_auto: cover property (@(posedge pclk) disable iff (!presetn) auto_go);
  c_host: cover property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ctrl && !pins_s.auto_start);
  c_load: cover property (@(posedge pclk) disable iff (!presetn)
    load_en_out && load_done_in);
  c_bypass: cover property (@(posedge pclk) disable iff (!presetn)
    pins_s.bypass && pins_s.por_reset);
endmodule
`default_nettype wire

// File: tb/csr_partner.sv
/*
  Board-side model: target chain init line, loader done pulse, board reset.
  Assumes an external pull-up on the program pin and the pclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module csr_partner #(
  parameter int CLEAR_CYC = 6,
  parameter int LOAD_CYC = 5,
  parameter int PULSE_CYC = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic target_program_out,
  input wire logic target_program_oe_n,
  input wire logic load_en_out,
  input wire logic board_go,
  output logic program_instruction_wire,
  output logic target_ready_in,
  output logic load_done_in,
  output logic por_reset_in
);
  int clr_q;
  int load_q;
  int pulse_q;
  // Released pin floats to the pull-up
  assign program_instruction_wire = target_program_oe_n ? 1'b1 : target_program_out;
  // Targets clear while pulled low and a while after
  assign target_ready_in = program_instruction_wire && (clr_q == 0);
  assign por_reset_in = (pulse_q != 0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_q <= 0;
    else if (!program_instruction_wire) clr_q <= CLEAR_CYC;
    else if (clr_q != 0) clr_q <= clr_q - 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_q <= 0;
      load_done_in <= 1'b0;
    end else begin
      load_q <= load_en_out ? load_q + 1 : 0;
      load_done_in <= load_en_out && (load_q == LOAD_CYC);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulse_q <= 0;
    else if (board_go) pulse_q <= PULSE_CYC;
    else if (pulse_q != 0) pulse_q <= pulse_q - 1;
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
/*
  Self-checking bench for csr_top: auto start, host start, program request,
  unmapped access and board reset bypass.
  Assumes the board-side model in csr_partner and zero-wait APB.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [csr_pkg::APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic auto_sel, bypass, ready, card_wait, done, por_rst, board_go;
  logic program_instruction_out, program_instruction_oe_n, attr_sel, por_test, load_en, program_instruction_wire;
  int failures = 0;
  int checked = 0;

  csr_top #(.POR_CYCLES(40), .PROGRAM_INSTRUCTION_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .auto_start_select_in(auto_sel),
    .por_bypass_in(bypass), .por_reset_in(por_rst),
    .target_ready_in(ready), .card_wait_in(card_wait),
    .load_done_in(done), .target_program_out(program_instruction_out),
    .target_program_oe_n(program_instruction_oe_n), .card_attr_select_out(attr_sel),
    .por_test_out(por_test), .load_en_out(load_en));

  csr_partner part (
    .pclk(pclk), .presetn(presetn), .target_program_out(program_instruction_out),
    .target_program_oe_n(program_instruction_oe_n), .load_en_out(load_en),
    .board_go(board_go), .program_instruction_wire(program_instruction_wire), .target_ready_in(ready),
    .load_done_in(done), .por_reset_in(por_rst));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task end_sim();
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_sig(ref logic s, input logic v, input int lim,
                          input string nm);
    for (int i = 0; i < lim; i++) begin
      @(posedge pclk);
      if (s === v) break;
    end
    chk(nm, {31'h0000_0000, v}, {31'h0000_0000, s});
  endtask

  task automatic hold(ref logic s, input logic v, input int n,
                      input string nm);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      if (s !== v) break;
    end
    chk(nm, {31'h0000_0000, v}, {31'h0000_0000, s});
  endtask

  // Called just after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-drives psel in this time step
    @(posedge pclk);
  endtask

  task do_reset(input logic m, input logic b);
    presetn <= 1'b0;
    auto_sel <= m;
    bypass <= b;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    #(25 * 5000);
    failures++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    auto_sel = 1'b1;
    bypass = 1'b0;
    board_go = 1'b0;
    card_wait = 1'b1;
    @(posedge pclk);
    do_reset(1'b1, 1'b0);
    @(posedge pclk);
    chk("card_attr", 32'h0000_0001, {31'h0000_0000, attr_sel});
    chk("por_test", 32'h0000_0001, {31'h0000_0000, por_test});
    wait_sig(por_test, 1'b0, 60, "por_done");
    wait_sig(program_instruction_oe_n, 1'b0, 10, "auto_program_instruction");
    chk("program_instruction_pin", 32'h0000_0000, {31'h0000_0000, program_instruction_wire});
    wait_sig(program_instruction_oe_n, 1'b1, 30, "program_instruction_rel");
    chk("load_early", 32'h0000_0000, {31'h0000_0000, load_en});
    wait_sig(load_en, 1'b1, 30, "load_on");
    chk("ready_load", 32'h0000_0001, {31'h0000_0000, ready});
    wait_sig(load_en, 1'b0, 20, "load_off");
    apb(1'b0, csr_pkg::STAT_OFS, 32'h0000_0000);
    chk("status_a", 32'h0000_0007, rd);

    do_reset(1'b0, 1'b0);
    hold(program_instruction_oe_n, 1'b1, 60, "no_auto");
    apb(1'b0, csr_pkg::STAT_OFS, 32'h0000_0000);
    chk("status_b", 32'h0000_0005, rd);
    apb(1'b1, csr_pkg::CTRL_OFS, 32'h0000_0001);
    wait_sig(program_instruction_oe_n, 1'b0, 8, "host_go");
    wait_sig(load_en, 1'b1, 60, "host_load");
    wait_sig(load_en, 1'b0, 20, "host_done");
    apb(1'b1, csr_pkg::CTRL_OFS, 32'h0000_0002);
    wait_sig(program_instruction_oe_n, 1'b0, 8, "program_instruction_req");
    wait_sig(program_instruction_oe_n, 1'b1, 30, "program_instruction_end");
    hold(load_en, 1'b0, 20, "program_instruction_only");
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    chk("bad_rd", 32'h0000_0000, rd);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    hold(program_instruction_oe_n, 1'b1, 10, "bad_wr");

    do_reset(1'b0, 1'b1);
    // Internal timer would need 40 cycles
    wait_sig(por_test, 1'b0, 8, "bypass_por");
    board_go <= 1'b1;
    @(posedge pclk);
    board_go <= 1'b0;
    card_wait <= 1'b0;
    wait_sig(por_test, 1'b1, 6, "board_rst");
    apb(1'b1, csr_pkg::CTRL_OFS, 32'h0000_0001);
    apb(1'b0, csr_pkg::STAT_OFS, 32'h0000_0000);
    chk("status_c", 32'h0000_0009, rd);
    apb(1'b0, csr_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl_c", 32'h0000_0000, rd);
    wait_sig(por_test, 1'b0, 60, "board_rel");
    hold(program_instruction_oe_n, 1'b1, 10, "start_drop");
    end_sim();
  end
endmodule
`default_nettype wire
